// file: core/hids_pkg.sv
`default_nettype none

package hids_pkg;

  // Host I/O address layout
  localparam int          HOST_ADDR_W        = 10;
  localparam logic [4:0]  ADAPTOR_WIN_A7_3   = 5'h1A;
  localparam logic [5:0]  SYSCTL_WIN_A7_2    = 6'h36;
  localparam int          WIN_BASE_LSB       = 8;
  localparam logic [1:0]  BASE_ANY_WINDOW    = 2'h3;

  // System-control register offsets within the sysctl window (A1..A0)
  localparam logic [1:0]  SYS_RESET_OFS      = 2'h0;
  localparam logic [1:0]  SYS_ANALYSE_OFS    = 2'h1;

  // Field positions and reset values
  localparam int          CTL_BIT            = 0;
  localparam int          ERR_BIT            = 0;
  localparam logic        RESET_CTL_RST      = 1'b0;
  localparam logic        ANALYSE_CTL_RST    = 1'b0;
  localparam logic [7:0]  DATA_ZERO          = 8'h00;

  // Timing
  localparam int          MCLK_PERIOD_NS     = 10;
  localparam int          ADAPTOR_CLK_NS     = 200;
  localparam int          ADAPTOR_HALF_CYC   = ADAPTOR_CLK_NS / (2 * MCLK_PERIOD_NS);

  localparam int          NUM_MODULES        = 4;

  typedef enum logic [3:0]
  {
    LINK_IDLE    = 4'b0001,
    LINK_WR_WAIT = 4'b0010,
    LINK_WR_ACT  = 4'b0100,
    LINK_RD_ACT  = 4'b1000
  } hids_link_t;

endpackage : hids_pkg

`default_nettype wire

// file: core/hids_clk_div.sv
`timescale 1ns/10ps
`default_nettype none

module hids_clk_div
#(
  parameter int HALF_CYC = hids_pkg::ADAPTOR_HALF_CYC
)
(
  input  wire logic mclk,
  input  wire logic rstn,
  output var  logic divClk
);
  import hids_pkg::*;

  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic          clk;
  } hids_div_t;

  hids_div_t s_q;
  hids_div_t s_d;

  if (HALF_CYC < 1)
  begin : gBadDiv
    $error("hids_clk_div: HALF_CYC must be at least 1");
  end

  // Free-running divider; output straight from a flop
  always_comb
  begin
    s_d = s_q;
    if (s_q.cnt == CW'(HALF_CYC - 1))
    begin
      s_d.cnt = '0;
      s_d.clk = ~s_q.clk;
    end
    else
    begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign divClk = s_q.clk;

endmodule : hids_clk_div

`default_nettype wire

// file: core/hids_host_port.sv
// Overview of operation
// - Selects assert only while their jumper-presence input is low.
// - Any base jumper low adds A8 and A9 to the board decode.
// - Base 00,01,10 pick one window; 11 answers in all four windows.
// - Adaptor select decodes A3..A7, sysctl select A2..A7, both qualified by bus enable.
// - Sysctl select opens the reset, analyse and error registers to host.
// - Writing bit 0 as 1 asserts reset or analyse; 0 clears it.
// - Reading the error register returns bit 0 set while chain reports error.
// - Adaptor access sequence built from host write, read and bus clock.
// - Chip select enables data buffer; write strobe sets its direction.
// - Host reset goes out inverted; the same control resets the link adaptor uninverted.
// - A1 and A2 select one of four adaptor registers.
// - Adaptor receives a 5 MHz clock.
// - Host reset and analyse can be jumpered onto the Up port.
// - Reset and analyse go to plug-in modules uninverted.
// - Error lines are wired-OR; any low source means error.
`timescale 1ns/10ps
`default_nettype none

module hids_host_port
#(
  parameter int NMOD     = hids_pkg::NUM_MODULES,
  parameter int HALF_CYC = hids_pkg::ADAPTOR_HALF_CYC
)
(
  input  wire logic                               mclk,
  input  wire logic                               rstn,
  input  wire logic [hids_pkg::HOST_ADDR_W-1:0]   hostAddr,
  input  wire logic [7:0]                         hostDataIn,
  output var  logic [7:0]                         hostDataOut,
  output var  logic                               hostDataOe,
  input  wire logic                               host_io_write_n,
  input  wire logic                               host_io_read_n,
  input  wire logic                               host_bus_clock,
  input  wire logic                               cpu_bus_enable0,
  input  wire logic                               base_jumper_bit0,
  input  wire logic                               base_jumper_bit1,
  input  wire logic                               link_jumper_present_n,
  input  wire logic                               sysctl_jumper_present_n,
  input  wire logic                               up_route_jumper_n,
  output var  logic                               adaptor_port_select_n,
  output var  logic                               sysctl_select_n,
  output var  logic                               adaptor_chip_sel_n,
  output var  logic                               adaptor_write_strobe_n,
  output var  logic [1:0]                         adaptorRegSel,
  output var  logic                               adaptorReset,
  output var  logic                               adaptorClk,
  output var  logic                               bufEnable_n,
  output var  logic                               bufToAdaptor,
  output var  logic                               host_reset_out_n,
  output var  logic                               upResetOut,
  output var  logic                               upResetOe,
  output var  logic                               upAnalyseOut,
  output var  logic                               upAnalyseOe,
  output var  logic                               moduleReset,
  output var  logic                               moduleAnalyse,
  input  wire logic [NMOD-1:0]                    moduleError_n,
  input  wire logic                               downError_n,
  input  wire logic                               subsysError_n,
  output var  logic                               upErrorOut,
  output var  logic                               upErrorOe
);
  import hids_pkg::*;

  typedef struct packed
  {
    hids_link_t  linkState;
    logic        hostClkPrev;
    logic        wrPrev_n;
    logic        resetCtl;
    logic        analyseCtl;
    logic        resetOut_n;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic        adaptorSel_n;
    logic        sysSel_n;
    logic        chipSel_n;
    logic        writeStrobe_n;
    logic        bufToAdp;
    logic [1:0]  regSel;
    logic        upResetOe;
    logic        upAnalyseOe;
    logic        upErrorOe;
  } hids_state_t;

  hids_state_t s_q;
  hids_state_t s_d;

  logic        baseHit;
  logic [1:0]  baseSel;
  logic        adaptorHit;
  logic        sysHit;
  logic        chainError;
  logic        hostClkRise;
  logic        writeLink;
  logic        readLink;
  logic        writeSys;
  logic        readSys;

  if (NMOD < 1)
  begin : gBadMod
    $error("hids_host_port: NMOD must be at least 1");
  end

  if (HALF_CYC < 1)
  begin : gBadClk
    $error("hids_host_port: HALF_CYC must be at least 1");
  end

  if (HOST_ADDR_W < WIN_BASE_LSB + 2)
  begin : gBadAddr
    $error("hids_host_port: host address too narrow for base decode");
  end

  // Base window: jumpers 11 leave A8/A9 out of the compare
  assign baseSel = {base_jumper_bit1, base_jumper_bit0};

  always_comb
  begin
    if (baseSel == BASE_ANY_WINDOW)
    begin
      baseHit = 1'b1;
    end
    else
    begin
      baseHit = (hostAddr[WIN_BASE_LSB +: 2] == baseSel);
    end
  end

  // Window decode on A7..A3 for adaptor, A7..A2 for sysctl; bus enable gates out DMA cycles
  assign adaptorHit = baseHit && cpu_bus_enable0
                      && (hostAddr[7:3] == ADAPTOR_WIN_A7_3)
                      && !link_jumper_present_n;
  assign sysHit     = baseHit && cpu_bus_enable0
                      && (hostAddr[7:2] == SYSCTL_WIN_A7_2)
                      && !sysctl_jumper_present_n;

  assign writeLink  = adaptorHit && !host_io_write_n;
  assign readLink   = adaptorHit && !host_io_read_n;
  assign writeSys   = sysHit && !host_io_write_n;
  assign readSys    = sysHit && !host_io_read_n;

  // Any error source pulling low counts
  assign chainError = !downError_n
                      || !subsysError_n
                      || !(&moduleError_n);

  // Inputs are synchronous, so a plain edge compare is safe here
  assign hostClkRise = host_bus_clock && !s_q.hostClkPrev;

  always_comb
  begin
    s_d             = s_q;
    s_d.hostClkPrev = host_bus_clock;
    s_d.wrPrev_n    = host_io_write_n;
    s_d.adaptorSel_n = !adaptorHit;
    s_d.sysSel_n    = !sysHit;
    s_d.regSel      = {hostAddr[2], hostAddr[1]};

    // Capture on the leading edge of a write so a long strobe stores once
    if (writeSys && s_q.wrPrev_n)
    begin
      case (hostAddr[1:0])
        SYS_RESET_OFS:
        begin
          s_d.resetCtl = hostDataIn[CTL_BIT];
        end
        SYS_ANALYSE_OFS:
        begin
          s_d.analyseCtl = hostDataIn[CTL_BIT];
        end
        // Offsets 2 and 3 hold no writable register
        default:
        begin
          s_d.resetCtl = s_q.resetCtl;
        end
      endcase
    end

    // Error reads back at any sysctl offset
    s_d.dataOe  = readSys;
    s_d.dataOut = DATA_ZERO;
    if (readSys)
    begin
      s_d.dataOut[ERR_BIT] = chainError;
    end

    // Writes wait one host clock edge so data settles before chip select
    case (s_q.linkState)
      LINK_IDLE:
      begin
        if (writeLink)
        begin
          s_d.linkState = LINK_WR_WAIT;
        end
        else if (readLink)
        begin
          s_d.linkState = LINK_RD_ACT;
        end
      end
      LINK_WR_WAIT:
      begin
        if (!writeLink)
        begin
          s_d.linkState = LINK_IDLE;
        end
        else if (hostClkRise)
        begin
          s_d.linkState = LINK_WR_ACT;
        end
      end
      LINK_WR_ACT:
      begin
        if (!writeLink)
        begin
          s_d.linkState = LINK_IDLE;
        end
      end
      LINK_RD_ACT:
      begin
        if (!readLink)
        begin
          s_d.linkState = LINK_IDLE;
        end
      end
      default:
      begin
        s_d.linkState = LINK_IDLE;
      end
    endcase

    s_d.chipSel_n = !((s_d.linkState == LINK_WR_ACT)
                      || (s_d.linkState == LINK_RD_ACT));
    s_d.writeStrobe_n = !((s_d.linkState == LINK_WR_WAIT)
                          || (s_d.linkState == LINK_WR_ACT));

    // Inverted copies live in their own flops so no pin hangs off a gate
    s_d.resetOut_n = !s_d.resetCtl;
    s_d.bufToAdp   = !s_d.writeStrobe_n;

    // Up reset and analyse are driven only while the route jumper is fitted; up error is not gated
    s_d.upResetOe   = !up_route_jumper_n && s_d.resetCtl;
    s_d.upAnalyseOe = !up_route_jumper_n && s_d.analyseCtl;
    s_d.upErrorOe   = chainError;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q               <= '0;
      s_q.linkState     <= LINK_IDLE;
      s_q.hostClkPrev   <= 1'b1;
      s_q.wrPrev_n      <= 1'b1;
      s_q.resetCtl      <= RESET_CTL_RST;
      s_q.analyseCtl    <= ANALYSE_CTL_RST;
      s_q.resetOut_n    <= !RESET_CTL_RST;
      s_q.bufToAdp      <= 1'b0;
      s_q.adaptorSel_n  <= 1'b1;
      s_q.sysSel_n      <= 1'b1;
      s_q.chipSel_n     <= 1'b1;
      s_q.writeStrobe_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Adaptor clock runs free; the adaptor needs no phase relation to the host
  hids_clk_div
  #(
    .HALF_CYC (HALF_CYC)
  )
  uClkDiv
  (
    .mclk   (mclk),
    .rstn   (rstn),
    .divClk (adaptorClk)
  );

  assign hostDataOut            = s_q.dataOut;
  assign hostDataOe             = s_q.dataOe;
  assign adaptor_port_select_n  = s_q.adaptorSel_n;
  assign sysctl_select_n        = s_q.sysSel_n;
  assign adaptor_chip_sel_n     = s_q.chipSel_n;
  assign adaptor_write_strobe_n = s_q.writeStrobe_n;
  assign adaptorRegSel          = s_q.regSel;
  assign bufEnable_n            = s_q.chipSel_n;
  assign bufToAdaptor           = s_q.bufToAdp;
  assign host_reset_out_n       = s_q.resetOut_n;
  assign adaptorReset           = s_q.resetCtl;
  assign moduleReset            = s_q.resetCtl;
  assign moduleAnalyse          = s_q.analyseCtl;
  // Open-drain pins only ever pull low; the enables carry the state
  assign upResetOut             = 1'b0;
  assign upResetOe              = s_q.upResetOe;
  assign upAnalyseOut           = 1'b0;
  assign upAnalyseOe            = s_q.upAnalyseOe;
  assign upErrorOut             = 1'b0;
  assign upErrorOe              = s_q.upErrorOe;

endmodule : hids_host_port

`default_nettype wire

// file: tb/hids_host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host side bus clock; the host bus clock runs free, so it never stops
module hids_host_bus_model
#(
  parameter int HALF_NS = 20
)
(
  output var logic host_bus_clock
);
  initial
  begin
    host_bus_clock = 1'b0;
    forever #(HALF_NS) host_bus_clock = ~host_bus_clock;
  end
endmodule : hids_host_bus_model

`default_nettype wire

// file: tb/hids_host_port_sva.sv
`timescale 1ns/10ps
`default_nettype none

module hids_host_port_sva
  import hids_pkg::*;
#(
  parameter int NMOD     = NUM_MODULES,
  parameter int HALF_CYC = ADAPTOR_HALF_CYC
)
(
  input wire logic                             mclk,
  input wire logic                             rstn,
  input wire logic [hids_pkg::HOST_ADDR_W-1:0] hostAddr,
  input wire logic [7:0]                       hostDataIn,
  input wire logic [7:0]                       hostDataOut,
  input wire logic                             hostDataOe,
  input wire logic                             host_io_write_n,
  input wire logic                             host_io_read_n,
  input wire logic                             cpu_bus_enable0,
  input wire logic                             base_jumper_bit0,
  input wire logic                             base_jumper_bit1,
  input wire logic                             link_jumper_present_n,
  input wire logic                             sysctl_jumper_present_n,
  input wire logic                             adaptor_port_select_n,
  input wire logic                             sysctl_select_n,
  input wire logic                             adaptor_chip_sel_n,
  input wire logic                             adaptor_write_strobe_n,
  input wire logic [1:0]                       adaptorRegSel,
  input wire logic                             adaptorReset,
  input wire logic                             adaptorClk,
  input wire logic                             bufEnable_n,
  input wire logic                             bufToAdaptor,
  input wire logic                             host_reset_out_n,
  input wire logic                             moduleReset,
  input wire logic                             moduleAnalyse,
  input wire logic [NMOD-1:0]                  moduleError_n,
  input wire logic                             downError_n,
  input wire logic                             subsysError_n,
  input wire logic                             upErrorOe
);
  logic       baseOk;
  logic       sysHit;
  logic       adpHit;
  logic       errAny;
  logic       seenEdge;
  logic       adpClkPrev;
  logic [7:0] run;
  assign baseOk = ({base_jumper_bit1, base_jumper_bit0} == BASE_ANY_WINDOW)
                  || (hostAddr[9:8] == {base_jumper_bit1, base_jumper_bit0});
  assign sysHit = cpu_bus_enable0 && !sysctl_jumper_present_n && baseOk
                  && (hostAddr[7:2] == SYSCTL_WIN_A7_2);
  assign adpHit = cpu_bus_enable0 && !link_jumper_present_n && baseOk
                  && (hostAddr[7:3] == ADAPTOR_WIN_A7_3);
  assign errAny = !(&moduleError_n) || !downError_n || !subsysError_n;
  // First toggle after reset is skipped, since seenEdge is still clear when that toggle is sampled
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      seenEdge   <= 1'b0;
      adpClkPrev <= 1'b0;
      run        <= 8'h00;
    end
    else if (adaptorClk != adpClkPrev)
    begin
      seenEdge   <= 1'b1;
      adpClkPrev <= adaptorClk;
      run        <= 8'h01;
    end
    else
    begin
      run <= run + 8'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_sys_hit: assert property (sysHit |=> !sysctl_select_n)
    else $error("sysctl select missing on window hit");
  a_sys_miss: assert property (!sysHit |=> sysctl_select_n)
    else $error("sysctl select on window miss");
  a_link_gate: assert property (link_jumper_present_n |=> adaptor_port_select_n)
    else $error("adaptor select without jumper");
  a_reset_write: assert property ((sysHit && $fell(host_io_write_n)
    && hostAddr[1:0] == SYS_RESET_OFS) |=> (host_reset_out_n != $past(hostDataIn[0])))
    else $error("reset control not written");
  a_analyse_write: assert property ((sysHit && $fell(host_io_write_n)
    && hostAddr[1:0] == SYS_ANALYSE_OFS) |=> (moduleAnalyse == $past(hostDataIn[0])))
    else $error("analyse control not written");
  a_reset_fanout: assert property (host_reset_out_n == !adaptorReset
    && moduleReset == adaptorReset)
    else $error("reset outputs disagree");
  a_error_read: assert property (sysHit && !host_io_read_n ##1 sysHit && !host_io_read_n
    |-> hostDataOe && hostDataOut[ERR_BIT] == $past(errAny))
    else $error("error read value wrong");
  a_write_strobe: assert property (adpHit && !host_io_write_n ##1 adpHit && !host_io_write_n
    |-> !adaptor_write_strobe_n && bufToAdaptor)
    else $error("adaptor write strobe missing");
  a_read_select: assert property (adpHit && !host_io_read_n ##1 adpHit && !host_io_read_n
    |-> !adaptor_chip_sel_n && adaptor_write_strobe_n)
    else $error("adaptor read select missing");
  a_buf_enable: assert property (bufEnable_n == adaptor_chip_sel_n)
    else $error("buffer enable differs from chip select");
  a_reg_select: assert property (adpHit |=> adaptorRegSel == $past(hostAddr[2:1]))
    else $error("adaptor register select wrong");
  a_clk_half: assert property (seenEdge && $changed(adaptorClk) |-> run == 8'(HALF_CYC))
    else $error("adaptor clock half period wrong");
  a_err_wired: assert property (errAny ##1 errAny |-> upErrorOe)
    else $error("error not passed up");
endmodule : hids_host_port_sva

bind hids_host_port hids_host_port_sva #(.NMOD(NMOD), .HALF_CYC(HALF_CYC)) i_sva (.mclk, .rstn,
  .hostAddr, .hostDataIn, .hostDataOut, .hostDataOe, .host_io_write_n, .host_io_read_n,
  .cpu_bus_enable0, .base_jumper_bit0, .base_jumper_bit1, .link_jumper_present_n,
  .sysctl_jumper_present_n, .adaptor_port_select_n, .sysctl_select_n, .adaptor_chip_sel_n,
  .adaptor_write_strobe_n, .adaptorRegSel, .adaptorReset, .adaptorClk, .bufEnable_n,
  .bufToAdaptor, .host_reset_out_n, .moduleReset, .moduleAnalyse, .moduleError_n,
  .downError_n, .subsysError_n, .upErrorOe);

`default_nettype wire

// file: tb/tb_host_io_decode_sysctl.sv
`timescale 1ns/10ps
`default_nettype none

module tb_host_io_decode_sysctl;
  import hids_pkg::*;
  logic       mclk, rstn, host_io_write_n, host_io_read_n, host_bus_clock, cpu_bus_enable0;
  logic       base_jumper_bit0, base_jumper_bit1, link_jumper_present_n, up_route_jumper_n;
  logic       sysctl_jumper_present_n, downError_n, subsysError_n, hostDataOe, adaptorReset;
  logic       adaptor_chip_sel_n, adaptor_write_strobe_n, host_reset_out_n, moduleReset;
  logic       moduleAnalyse, upResetOe, upErrorOe, csSeen, wsSeen, rdData, rdOe;
  logic       upAnalyseOe, upResetOut, upAnalyseOut, upErrorOut;
  logic [9:0] hostAddr;
  logic [7:0] hostDataIn, hostDataOut;
  logic [3:0] moduleError_n;
  logic [1:0] adaptorRegSel, regSel;
  int         n_mismatch, checked;

  hids_host_bus_model i_host (.host_bus_clock);
  hids_host_port #(.NMOD(4), .HALF_CYC(2)) i_dut (.mclk, .rstn, .hostAddr, .hostDataIn,
    .hostDataOut, .hostDataOe, .host_io_write_n, .host_io_read_n, .host_bus_clock,
    .cpu_bus_enable0, .base_jumper_bit0, .base_jumper_bit1, .link_jumper_present_n,
    .sysctl_jumper_present_n, .up_route_jumper_n, .adaptor_port_select_n(), .sysctl_select_n(),
    .adaptor_chip_sel_n, .adaptor_write_strobe_n, .adaptorRegSel, .adaptorReset, .adaptorClk(),
    .bufEnable_n(), .bufToAdaptor(), .host_reset_out_n, .upResetOut, .upResetOe,
    .upAnalyseOut, .upAnalyseOe, .moduleReset, .moduleAnalyse, .moduleError_n,
    .downError_n, .subsysError_n, .upErrorOut, .upErrorOe);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One host access held six cycles, long enough to span a host bus clock rise
  task automatic acc(input logic [9:0] a, input logic wr, input logic d);
    @(posedge mclk) #1;
    hostAddr = a;
    hostDataIn = {7'h00, d};
    if (wr) host_io_write_n = 1'b0;
    else host_io_read_n = 1'b0;
    csSeen = 1'b0;
    wsSeen = 1'b0;
    repeat (6)
    begin
      @(posedge mclk) #1;
      csSeen |= !adaptor_chip_sel_n;
      wsSeen |= !adaptor_write_strobe_n;
    end
    {rdData, rdOe, regSel} = {hostDataOut[0], hostDataOe, adaptorRegSel};
    host_io_write_n = 1'b1;
    host_io_read_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask : acc

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  initial
  begin
    {rstn, host_io_write_n, host_io_read_n, cpu_bus_enable0} = 4'h7;
    {base_jumper_bit1, base_jumper_bit0, link_jumper_present_n} = 3'h0;
    {sysctl_jumper_present_n, up_route_jumper_n, downError_n, subsysError_n} = 4'h7;
    {hostAddr, hostDataIn, moduleError_n} = {10'h000, 8'h00, 4'hF};
    repeat (2) @(posedge mclk);
    #1 rstn = 1'b1;
    check(host_reset_out_n, 8'h01);
    check(moduleAnalyse, 8'h00);
    for (int b = 0; b < 4; b++)
      for (int w = 0; w < 4; w++)
      begin
        {base_jumper_bit1, base_jumper_bit0} = b[1:0];
        acc({w[1:0], 8'hD8}, 1'b1, 1'b1);
        check(host_reset_out_n, {7'h00, !(b == 3 || w == b)});
        acc({b[1:0], 8'hD8}, 1'b1, 1'b0);
      end
    acc(10'h0D9, 1'b1, 1'b1);
    check(moduleAnalyse, 8'h01);
    check(upAnalyseOe, 8'h00);
    acc(10'h0D9, 1'b1, 1'b0);
    check(moduleAnalyse, 8'h00);
    acc(10'h0DA, 1'b1, 1'b1);
    check(moduleReset, 8'h00);
    sysctl_jumper_present_n = 1'b1;
    acc(10'h0D8, 1'b1, 1'b1);
    check(moduleReset, 8'h00);
    {sysctl_jumper_present_n, cpu_bus_enable0} = 2'h0;
    acc(10'h0D8, 1'b1, 1'b1);
    check(moduleReset, 8'h00);
    {cpu_bus_enable0, up_route_jumper_n} = 2'h2;
    acc(10'h0D8, 1'b1, 1'b1);
    check(upResetOe, 8'h01);
    check(adaptorReset, 8'h01);
    acc(10'h0D8, 1'b1, 1'b0);
    check(upResetOe, 8'h00);
    acc(10'h0D9, 1'b1, 1'b1);
    check(upAnalyseOe, 8'h01);
    acc(10'h0D9, 1'b1, 1'b0);
    check(upAnalyseOe, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      moduleError_n = (i == 0) ? 4'hB : 4'hF;
      {downError_n, subsysError_n} = {i != 1, i != 2};
      acc(10'h0DB, 1'b0, 1'b0);
      check(rdData, {7'h00, i < 3});
      check(rdOe, 8'h01);
      check(upErrorOe, {7'h00, i < 3});
      check({upResetOut, upAnalyseOut, upErrorOut}, 8'h00);
    end
    acc(10'h0D4, 1'b1, 1'b1);
    check({wsSeen, csSeen}, 8'h03);
    check(regSel, 8'h02);
    acc(10'h0D2, 1'b0, 1'b0);
    check({wsSeen, csSeen}, 8'h01);
    check(regSel, 8'h01);
    link_jumper_present_n = 1'b1;
    acc(10'h0D4, 1'b1, 1'b1);
    check({wsSeen, csSeen}, 8'h00);
    close_out();
  end
endmodule : tb_host_io_decode_sysctl

`default_nettype wire
